// file: pss_pkg.sv
// constants, register map and types of the scan sequencer
`default_nettype none
package pss_pkg;
	localparam int unsigned CLK_PERIOD_NS    = 40;
	localparam int unsigned MIN_INTERVAL_NS  = 10000;
	localparam int unsigned MIN_UNIT_CYCLES  = (MIN_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned UNIT_TIME_NS     = 1000000;
	localparam int unsigned UNIT_CYCLES_DEF  = UNIT_TIME_NS / CLK_PERIOD_NS;

	localparam int unsigned LINE_COUNT       = 10;
	localparam int unsigned PROG_WIDTH       = 8;
	localparam int unsigned INTERVAL_WIDTH   = 16;
	localparam int unsigned CHAN_WIDTH       = 4;
	localparam int unsigned MUX_INPUTS       = 16;
	localparam int unsigned UNIT_WIDTH       = 16;

	localparam logic [11:0] ADDR_CTRL        = 12'h000;
	localparam logic [11:0] ADDR_UNIT        = 12'h004;
	localparam logic [11:0] ADDR_STATUS      = 12'h008;
	localparam logic [11:0] ADDR_PULSES      = 12'h00C;

	localparam int unsigned CTRL_MONO_BIT    = 0;
	localparam int unsigned CTRL_CASCADE_BIT = 1;
	localparam int unsigned CTRL_HIGH_LSB    = 8;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

	localparam int unsigned STAT_CHAN_LSB    = 0;
	localparam int unsigned STAT_RUN_BIT     = 4;
	localparam int unsigned STAT_RESET_BIT   = 5;
	localparam int unsigned STAT_TRIG_BIT    = 6;
	localparam int unsigned STAT_PROG_LSB    = 8;

	typedef enum logic [2:0] {
		PSS_IDLE  = 3'b001,
		PSS_RUN   = 3'b010,
		PSS_HOLD  = 3'b100
	} pss_state_e;
endpackage : pss_pkg
`default_nettype wire

// file: pss_lines_if.sv
// synchronised relay-driver lines passed from the line front end to the core
`timescale 1ns/1ps
`default_nettype none
interface pss_lines_if;
	import pss_pkg::*;
	logic [PROG_WIDTH-1:0] prog;
	logic                  reset_level;
	logic                  trigger_rise;
	logic                  trigger_level;
	modport front (output prog, output reset_level, output trigger_rise, output trigger_level);
	modport core  (input prog, input reset_level, input trigger_rise, input trigger_level);
endinterface : pss_lines_if
`default_nettype wire

// file: pss_line_sync.sv
// two-stage synchroniser and trigger edge detect for the ten driver lines
`timescale 1ns/1ps
`default_nettype none
module pss_line_sync
	import pss_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic [PROG_WIDTH-1:0] interval_program_lines,
	input  wire logic                  sequencer_reset_line,
	input  wire logic                  scan_trigger_line,
	pss_lines_if.front                 lines
);
	logic [LINE_COUNT-1:0] meta;
	logic [LINE_COUNT-1:0] stable;
	logic                  trig_prev;
	logic [LINE_COUNT-1:0] next_meta;
	logic [LINE_COUNT-1:0] next_stable;
	logic                  next_trig_prev;

	always_comb begin
		// open crosspoint pulls high, closed one reads low: the level is taken as is
		next_meta      = {scan_trigger_line, sequencer_reset_line, interval_program_lines};
		next_stable    = meta;
		next_trig_prev = stable[LINE_COUNT-1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta      <= '0;
			stable    <= '0;
			trig_prev <= 1'b0;
		end else begin
			meta      <= next_meta;
			stable    <= next_stable;
			trig_prev <= next_trig_prev;
		end
	end

	assign lines.prog          = stable[PROG_WIDTH-1:0];
	assign lines.reset_level   = stable[PROG_WIDTH];
	assign lines.trigger_level = stable[LINE_COUNT-1];
	assign lines.trigger_rise  = stable[LINE_COUNT-1] & ~trig_prev;
endmodule : pss_line_sync
`default_nettype wire

// file: pss_sequencer.sv
// scan sequencer top: interval timer, channel counter, mux select and apb registers
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer
	import pss_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES = UNIT_CYCLES_DEF
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [PROG_WIDTH-1:0] interval_program_lines,
	input  wire logic                  sequencer_reset_line,
	input  wire logic                  scan_trigger_line,
	output logic [CHAN_WIDTH-1:0]      channel_select_inputs,
	output logic [MUX_INPUTS-1:0]      mux_input_enable,
	output logic                       count_pulse,
	output logic [LINE_COUNT-1:0]      relay_on
);
	localparam logic [UNIT_WIDTH-1:0] UNIT_RESET = UNIT_WIDTH'(UNIT_CYCLES);
	localparam logic [UNIT_WIDTH-1:0] UNIT_MIN   = UNIT_WIDTH'(MIN_UNIT_CYCLES);

	pss_lines_if lines ();

	pss_line_sync u_sync (
		.pclk                   (pclk),
		.presetn                (presetn),
		.interval_program_lines (interval_program_lines),
		.sequencer_reset_line   (sequencer_reset_line),
		.scan_trigger_line      (scan_trigger_line),
		.lines                  (lines.front)
	);

	// register state
	logic                      ctrl_mono;
	logic                      ctrl_cascade;
	logic [PROG_WIDTH-1:0]     ctrl_high;
	logic [UNIT_WIDTH-1:0]     unit_cycles;
	logic [31:0]               pulse_total;
	logic [31:0]               next_prdata;
	logic                      next_pslverr;
	logic                      next_ctrl_mono;
	logic                      next_ctrl_cascade;
	logic [PROG_WIDTH-1:0]     next_ctrl_high;
	logic [UNIT_WIDTH-1:0]     next_unit_cycles;
	logic [31:0]               next_pulse_total;

	// timer state
	pss_state_e                state;
	logic [UNIT_WIDTH-1:0]     unit_cnt;
	logic [INTERVAL_WIDTH-1:0] interval_cnt;
	logic [CHAN_WIDTH-1:0]     channel;
	logic [MUX_INPUTS-1:0]     mux_sel;
	logic                      pulse;
	logic [LINE_COUNT-1:0]     relay_q;
	pss_state_e                next_state;
	logic [UNIT_WIDTH-1:0]     next_unit_cnt;
	logic [INTERVAL_WIDTH-1:0] next_interval_cnt;
	logic [CHAN_WIDTH-1:0]     next_channel;
	logic [MUX_INPUTS-1:0]     next_mux_sel;
	logic                      next_pulse;
	logic [LINE_COUNT-1:0]     next_relay_q;

	logic                      setup_phase;
	logic                      write_take;
	logic                      addr_ok;
	logic [INTERVAL_WIDTH-1:0] interval_value;
	logic [UNIT_WIDTH-1:0]     unit_limit;
	logic                      unit_tick;
	logic                      interval_done;
	logic                      pulse_clear;

	assign setup_phase = psel & ~penable;
	assign write_take  = psel & penable & pwrite;
	assign pulse_clear = write_take && !pslverr && (paddr == ADDR_PULSES);
	assign addr_ok     = (paddr == ADDR_CTRL) || (paddr == ADDR_UNIT) ||
	                     (paddr == ADDR_STATUS) || (paddr == ADDR_PULSES);

	// apb read path: data and error latched in the setup phase
	always_comb begin
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (setup_phase) begin
			next_pslverr = ~addr_ok;
			next_prdata  = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					ADDR_CTRL: begin
						next_prdata[CTRL_MONO_BIT]                         = ctrl_mono;
						next_prdata[CTRL_CASCADE_BIT]                      = ctrl_cascade;
						next_prdata[CTRL_HIGH_LSB +: PROG_WIDTH]           = ctrl_high;
					end
					ADDR_UNIT: begin
						next_prdata[UNIT_WIDTH-1:0] = unit_cycles;
					end
					ADDR_STATUS: begin
						next_prdata[STAT_CHAN_LSB +: CHAN_WIDTH] = channel;
						next_prdata[STAT_RUN_BIT]                = (state == PSS_RUN);
						next_prdata[STAT_RESET_BIT]              = lines.reset_level;
						next_prdata[STAT_TRIG_BIT]               = lines.trigger_level;
						next_prdata[STAT_PROG_LSB +: PROG_WIDTH] = lines.prog;
					end
					ADDR_PULSES: begin
						next_prdata = pulse_total;
					end
					default: begin
						next_prdata = 32'h0000_0000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// control registers; status and unmapped writes are dropped
	always_comb begin
		next_ctrl_mono    = ctrl_mono;
		next_ctrl_cascade = ctrl_cascade;
		next_ctrl_high    = ctrl_high;
		next_unit_cycles  = unit_cycles;
		if (write_take && !pslverr) begin
			case (paddr)
				ADDR_CTRL: begin
					next_ctrl_mono    = pwdata[CTRL_MONO_BIT];
					next_ctrl_cascade = pwdata[CTRL_CASCADE_BIT];
					next_ctrl_high    = pwdata[CTRL_HIGH_LSB +: PROG_WIDTH];
				end
				ADDR_UNIT: begin
					// clamp keeps the pulse rate at or below the ceiling
					if (pwdata[UNIT_WIDTH-1:0] < UNIT_MIN) begin
						next_unit_cycles = UNIT_MIN;
					end else begin
						next_unit_cycles = pwdata[UNIT_WIDTH-1:0];
					end
				end
				default: begin
					next_unit_cycles = unit_cycles;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_mono    <= CTRL_RESET[CTRL_MONO_BIT];
			ctrl_cascade <= CTRL_RESET[CTRL_CASCADE_BIT];
			ctrl_high    <= CTRL_RESET[CTRL_HIGH_LSB +: PROG_WIDTH];
			unit_cycles  <= (UNIT_RESET < UNIT_MIN) ? UNIT_MIN : UNIT_RESET;
		end else begin
			ctrl_mono    <= next_ctrl_mono;
			ctrl_cascade <= next_ctrl_cascade;
			ctrl_high    <= next_ctrl_high;
			unit_cycles  <= next_unit_cycles;
		end
	end

	// pulse counter: a pulse in the cycle of a clearing write still counts
	always_comb begin
		next_pulse_total = pulse_total;
		if (pulse_clear) begin
			next_pulse_total = 32'h0000_0000;
		end
		if (pulse) begin
			next_pulse_total = next_pulse_total + 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_total <= 32'h0000_0000;
		end else begin
			pulse_total <= next_pulse_total;
		end
	end

	assign pready = 1'b1;

	// interval value: low byte from the lines, high byte only with cascade
	assign interval_value = ctrl_cascade ? {ctrl_high, lines.prog} : {{PROG_WIDTH{1'b0}}, lines.prog};
	assign unit_limit     = unit_cycles - UNIT_WIDTH'(1);
	// at or past the limit, so a unit shortened mid-run ticks at once instead of after a wrap
	assign unit_tick      = (unit_cnt >= unit_limit);
	assign interval_done  = unit_tick && (interval_value != '0) &&
	                        (interval_cnt >= interval_value - INTERVAL_WIDTH'(1));

	// timer and channel counter
	always_comb begin
		next_state        = state;
		next_unit_cnt     = unit_cnt;
		next_interval_cnt = interval_cnt;
		next_channel      = channel;
		next_pulse        = 1'b0;
		case (state)
			PSS_IDLE: begin
				if (lines.trigger_rise) begin
					next_state        = PSS_RUN;
					next_unit_cnt     = '0;
					next_interval_cnt = '0;
				end
			end
			PSS_RUN: begin
				next_unit_cnt = unit_tick ? '0 : unit_cnt + UNIT_WIDTH'(1);
				if (unit_tick) begin
					next_interval_cnt = interval_cnt + INTERVAL_WIDTH'(1);
				end
				if (interval_done) begin
					next_pulse        = 1'b1;
					next_interval_cnt = '0;
					next_channel      = channel + CHAN_WIDTH'(1);
					if (ctrl_mono) begin
						next_state = PSS_HOLD;
					end
				end
			end
			PSS_HOLD: begin
				// one-shot finished; a new trigger rearms it
				if (lines.trigger_rise) begin
					next_state        = PSS_RUN;
					next_unit_cnt     = '0;
					next_interval_cnt = '0;
				end
			end
			default: begin
				next_state = PSS_IDLE;
			end
		endcase
		if (lines.reset_level) begin
			next_state        = PSS_IDLE;
			next_unit_cnt     = '0;
			next_interval_cnt = '0;
			next_channel      = '0;
			next_pulse        = 1'b0;
		end
		next_mux_sel = MUX_INPUTS'(1) << next_channel;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= PSS_IDLE;
			unit_cnt     <= '0;
			interval_cnt <= '0;
			channel      <= '0;
			mux_sel      <= MUX_INPUTS'(1);
			pulse        <= 1'b0;
		end else begin
			state        <= next_state;
			unit_cnt     <= next_unit_cnt;
			interval_cnt <= next_interval_cnt;
			channel      <= next_channel;
			mux_sel      <= next_mux_sel;
			pulse        <= next_pulse;
		end
	end

	// relay indication, one flop behind the synchronised lines
	always_comb begin
		next_relay_q = ~{lines.trigger_level, lines.reset_level, lines.prog};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_q <= '0;
		end else begin
			relay_q <= next_relay_q;
		end
	end

	assign channel_select_inputs = channel;
	assign mux_input_enable      = mux_sel;
	assign count_pulse           = pulse;
	assign relay_on              = relay_q;
endmodule : pss_sequencer
`default_nettype wire

// file: pss_sequencer_props.sv
// concurrent checks on the scan sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_props
	import pss_pkg::*;
#(
	parameter int unsigned UNIT_CYCLES = UNIT_CYCLES_DEF
)(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic [11:0]           paddr,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [PROG_WIDTH-1:0] interval_program_lines,
	input wire logic                  sequencer_reset_line,
	input wire logic                  scan_trigger_line,
	input wire logic [CHAN_WIDTH-1:0] channel_select_inputs,
	input wire logic [MUX_INPUTS-1:0] mux_input_enable,
	input wire logic                  count_pulse,
	input wire logic [LINE_COUNT-1:0] relay_on
);
	logic [15:0] gap;
	logic [15:0] next_gap;
	wire logic [9:0] pins = {scan_trigger_line, sequencer_reset_line, interval_program_lines};
	wire logic unmapped = !(paddr inside {ADDR_CTRL, ADDR_UNIT, ADDR_STATUS, ADDR_PULSES});
	// cycles since the last count pulse, saturating
	always_comb next_gap = count_pulse ? 16'h0000 : ((gap == 16'hFFFF) ? gap : gap + 16'h0001);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) gap <= 16'hFFFF;
		else gap <= next_gap;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_MUX_ONEHOT: assert property (mux_input_enable == (16'h0001 << channel_select_inputs))
		else $error("mux enable differs from channel");
	AST_PULSE_ADV: assert property (count_pulse |-> channel_select_inputs == 4'($past(channel_select_inputs) + 4'h1))
		else $error("channel did not advance on pulse");
	AST_CHAN_CAUSE: assert property ($changed(channel_select_inputs) |-> count_pulse || channel_select_inputs == 4'h0)
		else $error("channel moved without pulse");
	AST_RATE: assert property (count_pulse |-> gap >= 16'(MIN_UNIT_CYCLES - 1))
		else $error("count pulses too close");
	AST_RESET_CLR: assert property (sequencer_reset_line [*4] |-> channel_select_inputs == 4'h0 && !count_pulse)
		else $error("reset line did not clear channel");
	AST_SLVERR: assert property (psel && !penable |=> pslverr == $past(unmapped))
		else $error("error response wrong");
	AST_READY: assert property (psel && penable |-> pready)
		else $error("no ready in access phase");
	AST_RELAY: assert property (($past(presetn, 3) && $stable(pins)) [*4] |-> relay_on == ~pins)
		else $error("relay outputs wrong");
	COV_WRAP: cover property (count_pulse && channel_select_inputs == 4'h0);
	COV_SLVERR: cover property (psel && penable && pslverr);
	COV_RESET: cover property (sequencer_reset_line [*4]);
endmodule : pss_sequencer_props
bind pss_sequencer pss_sequencer_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.interval_program_lines(interval_program_lines), .sequencer_reset_line(sequencer_reset_line),
	.scan_trigger_line(scan_trigger_line), .channel_select_inputs(channel_select_inputs),
	.mux_input_enable(mux_input_enable), .count_pulse(count_pulse), .relay_on(relay_on));
`default_nettype wire

// file: pss_relay_model.sv
// mainframe relay drivers: ten open-collector lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module pss_relay_model #(
	parameter int HOLD = 20
)(
	input  wire logic pclk,
	output logic [9:0] lines
);
	// all crosspoints closed at power-up, so every line reads low
	logic [9:0] closed = 10'h3FF;
	assign lines = ~closed;
	task automatic set_lines(input logic [9:0] c);
		@(posedge pclk);
		closed <= c;
	endtask : set_lines
	// hold scaled down from the long settle time
	task automatic load_interval(input logic [7:0] v);
		set_lines(10'h3FF);
		set_lines({2'b11, ~v});
		set_lines({2'b10, ~v});
		repeat (HOLD) @(posedge pclk);
		set_lines({2'b11, ~v});
	endtask : load_interval
	task automatic fire_trigger();
		set_lines({2'b01, closed[7:0]});
		repeat (HOLD) @(posedge pclk);
		set_lines({2'b11, closed[7:0]});
	endtask : fire_trigger
endmodule : pss_relay_model
`default_nettype wire

// file: pss_sequencer_tb.sv
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_tb import pss_pkg::*;;
	localparam int UNIT = 250;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [9:0]  lines;
	logic [3:0]  chan;
	logic [15:0] mux;
	logic        pulse;
	logic [9:0]  relay;
	logic [7:0]  n;
	int          fails = 0;
	int          num_checks = 0;
	int          seed = 50;
	int          cyc = 0;
	int          last = 0;
	logic [32:0] rq[$];
	logic [35:0] cq[$];
	pss_sequencer #(.UNIT_CYCLES(UNIT)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.interval_program_lines(lines[7:0]), .sequencer_reset_line(lines[8]), .scan_trigger_line(lines[9]),
		.channel_select_inputs(chan), .mux_input_enable(mux), .count_pulse(pulse), .relay_on(relay));
	pss_relay_model #(.HOLD(20)) RLY (.pclk(pclk), .lines(lines));
	initial forever #20 pclk = ~pclk;
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic chk_apb(input logic [32:0] got);
		check(36'(got), rq.size() > 0 ? 36'(rq.pop_front()) : 36'bx);
	endtask : chk_apb
	task automatic chk_pulse(input logic [35:0] got);
		logic [35:0] e;
		e = cq.size() > 0 ? cq.pop_front() : 36'bx;
		if (e[35:20] === 16'h0000) e[35:20] = got[35:20];
		check(got, e);
	endtask : chk_pulse
	task automatic chk_relay(input logic [9:0] got, input logic [9:0] exp);
		check(36'(got), 36'(exp));
	endtask : chk_relay
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic drain(input int lim);
		int i;
		i = 0;
		while (cq.size() > 0 && i < lim) begin
			@(posedge pclk);
			i++;
		end
		if (cq.size() > 0) begin
			fails++;
			$display("BAD t=%0t left=%h exp=%h", $time, cq.size(), 0);
		end
	endtask : drain
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready === 1'b1 && !pwrite) chk_apb({pslverr, prdata});
		if (pulse === 1'b1) begin
			chk_pulse({16'(cyc - last), mux, chan});
			last = cyc;
		end
	end
	initial begin
		#(100000 * 40);
		fails++;
		$display("BAD t=%0t got=%h exp=%h", $time, cq.size(), 0);
		summarize();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ADDR_CTRL, {1'b0, CTRL_RESET});
		rd(ADDR_UNIT, 33'(UNIT));
		apb(1'b1, ADDR_UNIT, 32'h0000_012C);
		rd(ADDR_UNIT, {1'b0, 32'h0000_012C});
		apb(1'b1, ADDR_UNIT, 32'h0000_0005);
		rd(ADDR_UNIT, 33'(MIN_UNIT_CYCLES));
		apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
		rd(ADDR_STATUS, 33'h0);
		rd(12'h010 + (12'($random(seed)) & 12'h7F0), {1'b1, 32'h0000_0000});
		$display("registers done");
		RLY.load_interval(8'h00);
		apb(1'b1, ADDR_PULSES, 32'h0000_0000);
		RLY.fire_trigger();
		repeat (4 * UNIT) @(posedge pclk);
		rd(ADDR_PULSES, 33'h0);
		$display("zero interval done");
		n = 8'(1 + {$random(seed)} % 3);
		RLY.load_interval(n);
		apb(1'b1, ADDR_PULSES, 32'h0000_0000);
		for (int k = 1; k <= 17; k++) cq.push_back({16'((k > 1) ? n * UNIT : 0), 16'h1 << (k % 16), 4'(k % 16)});
		RLY.fire_trigger();
		drain(60 * UNIT);
		rd(ADDR_PULSES, 33'd17);
		RLY.load_interval(n);
		repeat (4) @(posedge pclk);
		rd(ADDR_STATUS, {17'h0, n, 8'h00});
		$display("scan done");
		apb(1'b1, ADDR_CTRL, 32'h0000_0103);
		rd(ADDR_CTRL, {1'b0, 32'h0000_0103});
		RLY.load_interval(8'h00);
		repeat (4) @(posedge pclk);
		chk_relay(relay, 10'h3FF);
		cq.push_back({16'h0000, 16'h0002, 4'h1});
		RLY.fire_trigger();
		drain(300 * UNIT);
		repeat (4 * UNIT) @(posedge pclk);
		rd(ADDR_STATUS, {1'b0, 32'h0000_0001});
		$display("cascade one-shot done");
		summarize();
	end
endmodule : pss_sequencer_tb
`default_nettype wire
